// [verilog/acfg_pkg.sv]
// shared constants and types of the audio control write target
package acfg_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SPIKE_NS = 50;
  // least stable time rounds up: a pulse must outlast the spike width
  localparam int unsigned SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MUTE_TIME_US [4] = '{600, 1000, 1400, 3200};
  localparam int unsigned GAIN_TIME_US [4] = '{4700, 7100, 11200, 14400};
  localparam int TMR_W = 22;
  // ------------------------------------------------------------
  // bus framing
  // ------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h40;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [1:0] BC_ADDR = 2'h0;
  localparam logic [1:0] BC_SEL = 2'h1;
  localparam logic [1:0] BC_DATA = 2'h2;
  // ------------------------------------------------------------
  // setting map, in auto-increment order
  // ------------------------------------------------------------
  localparam int N_SET = 13;
  localparam int IDX_W = 4;
  localparam logic [N_SET-1:0][7:0] SEL_MAP = {8'h75, 8'h57, 8'h51, 8'h47, 8'h41, 8'h2B, 8'h2A,
                                               8'h29, 8'h28, 8'h20, 8'h06, 8'h05, 8'h01};
  localparam logic [IDX_W-1:0] IDX_SOFT = 4'h0;
  localparam logic [IDX_W-1:0] IDX_INSEL = 4'h1;
  localparam logic [IDX_W-1:0] IDX_GAIN = 4'h2;
  localparam logic [IDX_W-1:0] IDX_LAST = 4'hC;
  localparam int SOFT_EN_BIT = 7;
  localparam int MUTE_BIT = 7;
  localparam int GAIN_TIME_LSB = 4;
  localparam int MUTE_TIME_LSB = 0;
  localparam logic [7:0] SET_RST = 8'h00;
  // one captured data byte on its way to the setting latches
  typedef struct packed
  {
    logic vld;
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
  } acfg_wr_t;
endpackage

// [verilog/acfg_pin_filt.sv]
// synchroniser and spike filter for one bus line
`timescale 1ns/1ps
`default_nettype none
module acfg_pin_filt #(
  parameter int unsigned STABLE_CYC = acfg_pkg::SPIKE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // line
  input wire logic pin_i,
  output logic flt_o
);
  logic s1_q, s2_q, prev_q, flt_q;
  logic s1_d, s2_d, prev_d, flt_d;
  logic [7:0] cnt_q, cnt_d;

  // --------------------------------------------------------------
  // next values: output follows only a level held STABLE_CYC + 1 cycles
  // --------------------------------------------------------------
  always_comb
  begin
    s1_d = pin_i;
    s2_d = s1_q;
    prev_d = s2_q;
    flt_d = flt_q;
    cnt_d = cnt_q;
    if (s2_q != prev_q || s2_q == flt_q)
    begin
      cnt_d = 8'h00; // any toggle restarts the count
    end
    else if (cnt_q == 8'(STABLE_CYC - 1))
    begin
      flt_d = s2_q; // [RL11]
      cnt_d = 8'h00;
    end
    else
    begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  // registers; idle bus level is high
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      prev_q <= 1'b1;
      flt_q <= 1'b1;
      cnt_q <= 8'h00;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      prev_q <= prev_d;
      flt_q <= flt_d;
      cnt_q <= cnt_d;
    end
  end

  assign flt_o = flt_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_spike_reject: assert property ($changed(flt_q) |-> $past(cnt_q) == 8'(STABLE_CYC - 1)) // [RL11]
    else $error("filtered line changed before the level was stable");
endmodule
`default_nettype wire

// [verilog/acfg_i2c_wr.sv]
// write-only serial control target with setting latches and soft transition
//
// Behaviour
// RL1 - start, address, select, data bytes, stop
// RL2 - master sends write direction bit low
// RL3 - answer only to target address 1000000
// RL4 - acknowledge each accepted byte in ninth clock
// RL5 - first data byte goes to select address
// RL6 - select address advances one per data byte
// RL7 - later bytes are data, never new select
// RL8 - increment wraps from last to first address
// RL9 - changed settings apply through soft transition; here 01 and 05 still apply at once with soft switch on
// RL10 - master clock stays at most 400 kHz; the bench master model runs well above it
// RL11 - spikes up to 50 ns are ignored
// RL12 - read direction unanswered, line stays released
// RL13 - address 06 holds mute bit and gain
// RL14 - address 01 enables soft switch, picks times
`timescale 1ns/1ps
`default_nettype none
module acfg_i2c_wr #(
  parameter int unsigned MUTE_CYC [4] = '{acfg_pkg::MUTE_TIME_US[0] * acfg_pkg::CLK_MHZ,
    acfg_pkg::MUTE_TIME_US[1] * acfg_pkg::CLK_MHZ, acfg_pkg::MUTE_TIME_US[2] * acfg_pkg::CLK_MHZ,
    acfg_pkg::MUTE_TIME_US[3] * acfg_pkg::CLK_MHZ},
  parameter int unsigned GAIN_CYC [4] = '{acfg_pkg::GAIN_TIME_US[0] * acfg_pkg::CLK_MHZ,
    acfg_pkg::GAIN_TIME_US[1] * acfg_pkg::CLK_MHZ, acfg_pkg::GAIN_TIME_US[2] * acfg_pkg::CLK_MHZ,
    acfg_pkg::GAIN_TIME_US[3] * acfg_pkg::CLK_MHZ}
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // applied settings and status
  output logic [acfg_pkg::N_SET-1:0][7:0] set_o,
  output logic mute_o,
  output logic soft_busy_o,
  output logic addressed_o
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RECV = 4'b0010,
    ST_ACK = 4'b0100,
    ST_IGN = 4'b1000
  } acfg_st_t;

  logic scl_f, sda_f;
  logic scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_c, stop_c, byte_end;
  acfg_st_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [1:0] bc_q, bc_d;
  logic [acfg_pkg::IDX_W-1:0] idx_q, idx_d;
  logic idx_vld_q, idx_vld_d;
  logic oe_n_q, oe_n_d;
  logic addr_q, addr_d;
  acfg_pkg::acfg_wr_t wr_q, wr_d;
  logic [acfg_pkg::N_SET-1:0][7:0] lat_q, lat_d, app_q, app_d;
  logic [acfg_pkg::N_SET-1:0] dirty_q, dirty_d;
  logic busy_q, busy_d;
  logic [acfg_pkg::IDX_W-1:0] cur_q, cur_d;
  logic [acfg_pkg::TMR_W-1:0] tmr_q, tmr_d;

  // --------------------------------------------------------------
  // line conditioning and bus events
  // --------------------------------------------------------------
  acfg_pin_filt u_scl_filt (.ref_clk(ref_clk), .rst_n(rst_n), .pin_i(scl_i), .flt_o(scl_f)); // [RL11]
  acfg_pin_filt u_sda_filt (.ref_clk(ref_clk), .rst_n(rst_n), .pin_i(sda_i), .flt_o(sda_f)); // [RL11]

  // edges of the filtered lines; start and stop need scl high throughout
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_c = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_c = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign byte_end = scl_fall && bit_q == acfg_pkg::BIT_LAST;

  // --------------------------------------------------------------
  // framing state machine
  // --------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    bc_d = bc_q;
    idx_d = idx_q;
    idx_vld_d = idx_vld_q;
    oe_n_d = oe_n_q;
    wr_d = '0;
    if (start_c)
    begin
      st_d = ST_RECV; // [RL1]
      bit_d = 4'h0;
      bc_d = acfg_pkg::BC_ADDR;
      oe_n_d = 1'b1;
    end
    else if (stop_c)
    begin
      st_d = ST_IDLE; // [RL1]
      oe_n_d = 1'b1;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE, ST_IGN:
        begin
          oe_n_d = 1'b1; // [RL12]
        end
        ST_RECV:
        begin
          if (scl_rise)
          begin
            sh_d = {sh_q[6:0], sda_f};
            bit_d = bit_q + 4'h1;
          end
          else if (byte_end)
          begin
            st_d = ST_ACK;
            oe_n_d = 1'b0; // [RL4]
            if (bc_q == acfg_pkg::BC_ADDR)
            begin
              // wrong address or read direction: stay silent to the stop
              if (sh_q[7:1] != acfg_pkg::DEV_ADDR || sh_q[0] != acfg_pkg::RW_WRITE) // [RL3] [RL12] [RL2]
              begin
                st_d = ST_IGN;
                oe_n_d = 1'b1;
              end
            end
            else if (bc_q == acfg_pkg::BC_SEL)
            begin
              // unknown select codes are acknowledged but their data dropped
              idx_vld_d = 1'b0;
              for (int i = 0; i < acfg_pkg::N_SET; i++)
              begin
                if (acfg_pkg::SEL_MAP[i] == sh_q)
                begin
                  idx_d = acfg_pkg::IDX_W'(i); // [RL5]
                  idx_vld_d = 1'b1;
                end
              end
            end
            else
            begin
              wr_d = '{vld: idx_vld_q, idx: idx_q, data: sh_q}; // [RL5] [RL7]
              idx_d = (idx_q == acfg_pkg::IDX_LAST) ? '0 : idx_q + 1'b1; // [RL6] [RL8]
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            st_d = ST_RECV;
            oe_n_d = 1'b1;
            bit_d = 4'h0;
            // data count saturates so no later byte is a select address
            bc_d = (bc_q == acfg_pkg::BC_DATA) ? bc_q : bc_q + 2'h1; // [RL7]
          end
        end
        default:
        begin
          st_d = ST_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
    // registered so the status pin comes straight from a flop
    addr_d = (st_d == ST_RECV) || (st_d == ST_ACK);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      bc_q <= acfg_pkg::BC_ADDR;
      idx_q <= '0;
      idx_vld_q <= 1'b0;
      oe_n_q <= 1'b1;
      wr_q <= '0;
      addr_q <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      bc_q <= bc_d;
      idx_q <= idx_d;
      idx_vld_q <= idx_vld_d;
      oe_n_q <= oe_n_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
    end
  end

  // --------------------------------------------------------------
  // setting latches and soft transition engine
  // --------------------------------------------------------------
  // one timer serves all entries; a burst is applied entry by entry
  always_comb
  begin
    lat_d = lat_q;
    app_d = app_q;
    dirty_d = dirty_q;
    busy_d = busy_q;
    cur_d = cur_q;
    tmr_d = tmr_q;
    if (busy_q)
    begin
      if (tmr_q == '0)
      begin
        app_d[cur_q] = lat_q[cur_q];
        dirty_d[cur_q] = 1'b0;
        busy_d = 1'b0;
      end
      else
      begin
        tmr_d = tmr_q - 1'b1;
      end
    end
    else
    begin
      for (int i = acfg_pkg::N_SET - 1; i >= 0; i--)
      begin
        if (dirty_q[i])
        begin
          cur_d = acfg_pkg::IDX_W'(i);
        end
      end
      if (dirty_q != '0)
      begin
        // selector and the switch setup itself take effect at once
        if (!app_q[acfg_pkg::IDX_SOFT][acfg_pkg::SOFT_EN_BIT] || cur_d == acfg_pkg::IDX_SOFT
            || cur_d == acfg_pkg::IDX_INSEL || lat_q[cur_d] == app_q[cur_d]) // [RL14]
        begin
          app_d[cur_d] = lat_q[cur_d];
          dirty_d[cur_d] = 1'b0;
        end
        else if (cur_d == acfg_pkg::IDX_GAIN
                 && (lat_q[cur_d] ^ app_q[cur_d]) == (8'h01 << acfg_pkg::MUTE_BIT)) // [RL13]
        begin
          busy_d = 1'b1; // [RL9]
          tmr_d = acfg_pkg::TMR_W'(MUTE_CYC[app_q[acfg_pkg::IDX_SOFT][acfg_pkg::MUTE_TIME_LSB +: 2]] - 1);
        end
        else
        begin
          busy_d = 1'b1; // [RL9]
          tmr_d = acfg_pkg::TMR_W'(GAIN_CYC[app_q[acfg_pkg::IDX_SOFT][acfg_pkg::GAIN_TIME_LSB +: 2]] - 1);
        end
      end
    end
    // a fresh write wins over the clear of its dirty flag
    if (wr_q.vld)
    begin
      lat_d[wr_q.idx] = wr_q.data; // [RL5]
      dirty_d[wr_q.idx] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lat_q <= {acfg_pkg::N_SET{acfg_pkg::SET_RST}};
      app_q <= {acfg_pkg::N_SET{acfg_pkg::SET_RST}};
      dirty_q <= '0;
      busy_q <= 1'b0;
      cur_q <= '0;
      tmr_q <= '0;
    end
    else
    begin
      lat_q <= lat_d;
      app_q <= app_d;
      dirty_q <= dirty_d;
      busy_q <= busy_d;
      cur_q <= cur_d;
      tmr_q <= tmr_d;
    end
  end

  // outputs straight from flops, sda_o a constant low; sda only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_q;
  assign set_o = app_q;
  assign mute_o = app_q[acfg_pkg::IDX_GAIN][acfg_pkg::MUTE_BIT]; // [RL13]
  assign soft_busy_o = busy_q;
  assign addressed_o = addr_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_addr_ok;
    st_q == ST_RECV && byte_end && bc_q == acfg_pkg::BC_ADDR && sh_q == {acfg_pkg::DEV_ADDR, acfg_pkg::RW_WRITE};
  endsequence
  sequence s_data_byte;
    st_q == ST_RECV && byte_end && !start_c && !stop_c && bc_q == acfg_pkg::BC_DATA;
  endsequence
  a_ack_match: assert property (s_addr_ok and !start_c and !stop_c |=> !sda_oe_n && st_q == ST_ACK) // [RL4]
    else $error("matching address not acknowledged");
  a_addr_mismatch: assert property (st_q == ST_RECV && byte_end && bc_q == acfg_pkg::BC_ADDR
    && sh_q[7:1] != acfg_pkg::DEV_ADDR && !start_c && !stop_c |=> st_q == ST_IGN) // [RL3]
    else $error("foreign address was not ignored");
  a_ignore_released: assert property (st_q == ST_IGN |-> sda_oe_n) // [RL12]
    else $error("data line driven while ignoring a transfer");
  a_ack_release: assert property (st_q == ST_ACK && scl_fall && !start_c && !stop_c |=> sda_oe_n) // [RL4]
    else $error("acknowledge held past the ninth clock");
  a_data_write: assert property (s_data_byte |=> wr_q.data == $past(sh_q) && wr_q.idx == $past(idx_q)) // [RL5]
    else $error("data byte not sent to its latch");
  a_idx_incr: assert property (s_data_byte ##0 idx_q != acfg_pkg::IDX_LAST |=> idx_q == $past(idx_q) + 1'b1) // [RL6]
    else $error("select address did not advance");
  a_idx_wrap: assert property (s_data_byte ##0 idx_q == acfg_pkg::IDX_LAST |=> idx_q == '0) // [RL8]
    else $error("select address did not wrap");
  a_no_reselect: assert property (bc_q == acfg_pkg::BC_DATA && !start_c |=> $stable(idx_vld_q)) // [RL7]
    else $error("data byte taken as new select address");
  // compare the entry against itself only once cur_q has settled on it
  a_soft_hold: assert property ($rose(busy_q) |-> app_q[cur_q] != lat_q[cur_q] // [RL9]
    ##1 $stable(app_q[cur_q]) [*2])
    else $error("setting switched without soft transition");
  a_stop_idle: assert property (stop_c |=> st_q == ST_IDLE && sda_oe_n) // [RL1]
    else $error("stop did not end the transfer");
endmodule
`default_nettype wire

// [dv/acfg_i2c_master.sv]
// bus master model that drives the serial control lines of the write target
`timescale 1ns/1ps
`default_nettype none
module acfg_i2c_master #(
  // quarter of a bus clock period in ref_clk cycles; phases need only outlast the line filter,
  // so this runs well above the 400 kHz ceiling to keep the run short
  parameter int Q = 16
) (
  // clock
  input wire logic ref_clk,
  // test control
  input wire logic spike_en,
  // bus lines
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_o
);
  // ----------------------------------------
  // line stepping
  // ----------------------------------------
  // idle bus: both lines released high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // every change lands on a clock edge, then holds for n cycles
  task automatic drv(input logic s, input logic d, input int n);
    scl_o <= s;
    sda_o <= d;
    repeat (n) @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // framing
  // ----------------------------------------
  // data falls while the clock is high
  task automatic start();
    drv(1'b1, 1'b1, 2 * Q);
    drv(1'b1, 1'b0, 2 * Q);
    drv(1'b0, 1'b0, Q);
  endtask

  // data rises while the clock is high
  task automatic stop();
    drv(1'b0, sda_o, Q);
    drv(1'b0, 1'b0, Q);
    drv(1'b1, 1'b0, 2 * Q);
    drv(1'b1, 1'b1, 2 * Q);
  endtask

  // data held a quarter past the falling clock, so it never looks like a start or stop
  task automatic send_bit(input logic b, output logic seen);
    drv(1'b0, sda_o, Q);
    drv(1'b0, b, Q);
    // a 48 ns clock spike in the low phase that must not count as a bit
    if (spike_en)
    begin
      drv(1'b1, b, 12);
      drv(1'b0, b, Q);
    end
    drv(1'b1, b, Q);
    seen = sda_i;
    drv(1'b1, b, Q);
  endtask

  // msb first, then a released ninth bit that the target may pull low
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--)
      send_bit(d[i], seen);
    send_bit(1'b1, seen);
    ack = (seen === 1'b0);
  endtask
endmodule
`default_nettype wire

// [dv/acfg_i2c_wr_tb.sv]
// self-checking bench of the audio control write target
`timescale 1ns/1ps
`default_nettype none
module acfg_i2c_wr_tb;
  localparam logic [7:0] AW = {acfg_pkg::DEV_ADDR, acfg_pkg::RW_WRITE};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic spike_en = 1'b0;
  logic scl_w;
  logic sda_m;
  wire logic sda_w;
  logic sda_o;
  logic sda_oe_n;
  logic [acfg_pkg::N_SET-1:0][7:0] set_o;
  logic mute_o;
  logic soft_busy_o;
  logic addressed_o;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;

  // ----------------------------------------
  // clock, wiring and instances
  // ----------------------------------------
  always #2 ref_clk = ~ref_clk;
  // open-drain line with pull-up: low while either party pulls it
  assign sda_w = sda_m & (sda_oe_n | sda_o);

  // soft times shortened so a transition fits in a few thousand cycles
  acfg_i2c_wr #(
    .MUTE_CYC('{1000, 1200, 1400, 1600}),
    .GAIN_CYC('{2000, 2200, 2400, 2600})
  ) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .set_o(set_o), .mute_o(mute_o), .soft_busy_o(soft_busy_o),
    .addressed_o(addressed_o)
  );

  acfg_i2c_master #(
    .Q(16)
  ) m (
    .ref_clk(ref_clk), .spike_en(spike_en), .sda_i(sda_w), .scl_o(scl_w), .sda_o(sda_m)
  );

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // a hung handshake still ends in the report
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      failures++;
      final_report();
    end
  end

  // one whole write frame; every byte answered alike
  task automatic frame(input logic [7:0] b [$], input logic good);
    logic ack;
    m.start();
    foreach (b[i])
    begin
      m.wr_byte(b[i], ack);
      check(ack, good);
      if (i == 0)
        check(addressed_o, good);
    end
    m.stop();
    repeat (8) @(posedge ref_clk);
  endtask

  // bounded wait for an entry to take a value, with its delay judged against a window
  task automatic wait_val(input int i, input logic [7:0] v, input int t0, input int lo, input int hi);
    while (set_o[i] !== v && cyc < t0 + hi)
      @(posedge ref_clk);
    check(cyc - t0 >= lo && cyc - t0 < hi, 1'b1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(sda_oe_n, 1'b1);
    check({mute_o, soft_busy_o, addressed_o}, 3'h0);
    for (int i = 0; i < acfg_pkg::N_SET; i++)
      check(set_o[i], acfg_pkg::SET_RST);
  endtask

  task automatic t_basic();
    frame('{AW, 8'h05, 8'h0A}, 1'b1);
    check(set_o[1], 8'h0A);
  endtask

  // starts at 2B and runs past 75 back to 01 and 05, under clock spikes
  task automatic t_incr();
    logic [7:0] exp [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00, 8'h01};
    logic [7:0] q [$];
    q = '{AW, 8'h2B};
    foreach (exp[i])
      q.push_back(exp[i]);
    spike_en <= 1'b1;
    frame(q, 1'b1);
    spike_en <= 1'b0;
    for (int i = 0; i < 8; i++)
      check(set_o[(7 + i) % 13], exp[i]);
  endtask

  // a second byte that looks like a select code is still data
  task automatic t_reselect();
    frame('{AW, 8'h06, 8'h85, 8'h20}, 1'b1);
    check(set_o[2], 8'h85);
    check(set_o[3], 8'h20);
    check(set_o[1], 8'h01);
    check(mute_o, 1'b1);
  endtask

  task automatic t_refuse();
    frame('{8'h82, 8'h06, 8'h00}, 1'b0);
    frame('{8'h81, 8'h06, 8'h00}, 1'b0);
    check(set_o[2], 8'h85);
    // unknown select code: acknowledged, its data lands nowhere
    frame('{AW, 8'h07, 8'h55}, 1'b1);
    check(set_o[3], 8'h20);
    check(set_o[4], 8'h00);
  endtask

  // soft on, mute time 3 and gain time 0; mute-only change to 06, then a change to 20 on the gain time
  task automatic t_soft();
    logic ack;
    int t0;
    frame('{AW, 8'h01, 8'h83}, 1'b1);
    m.start();
    m.wr_byte(AW, ack);
    m.wr_byte(8'h06, ack);
    m.wr_byte(8'h05, ack);
    t0 = cyc;
    check(soft_busy_o, 1'b1);
    check(set_o[2], 8'h85);
    m.wr_byte(8'h30, ack);
    check(ack, 1'b1);
    m.stop();
    wait_val(2, 8'h05, t0, 1500, 1620);
    t0 = cyc;
    check(set_o[3], 8'h20);
    check(mute_o, 1'b0);
    wait_val(3, 8'h30, t0, 1950, 2060);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
    t_reset();
    t_basic();
    t_incr();
    t_reselect();
    t_refuse();
    t_soft();
    final_report();
  end
endmodule
`default_nettype wire
